/* logic/srw_regs.svh */
/*
 * timing constants for the supply reset watchdog.
 * assumes a 20 MHz system clock.
 */
`ifndef SRW_REGS_SVH
`define SRW_REGS_SVH
// ****************************************
// timing
// ****************************************
`define SRW_CLK_HZ 20000000
`define SRW_STRETCH_MS 140
`define SRW_TIMEOUT_MS 1600
`define SRW_TIMEOUT_MIN_MS 1000
`define SRW_TIMEOUT_MAX_MS 2250
`define SRW_STRETCH_CYC ((`SRW_CLK_HZ / 1000) * `SRW_STRETCH_MS)
`define SRW_TIMEOUT_CYC ((`SRW_CLK_HZ / 1000) * `SRW_TIMEOUT_MS)
`define SRW_CNT_W 32
// ****************************************
// reset values and steps
// ****************************************
`define SRW_OUT_RST 3'h3
`define SRW_CNT_ONE 32'h0000_0001
`endif

/* logic/srw_pkg.sv */
/*
 * types for the supply reset watchdog.
 * assumes nothing beyond the timing header.
 */
package srw_pkg;
    // ****************************************
    // kick level class
    // ****************************************
    typedef enum logic [1:0] {
        SRW_KICK_LOW = 2'h0,
        SRW_KICK_HIGH = 2'h1,
        SRW_KICK_MID = 2'h2
    } srw_kick_t;

    // ****************************************
    // reset sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        SRW_ST_HOLD = 3'h1,
        SRW_ST_RUN = 3'h2,
        SRW_ST_PULSE = 3'h4
    } srw_state_t;

    // ****************************************
    // kick pin as two signals
    // ****************************************
    typedef struct packed {
        logic drive_high;
        logic drive_low;
    } srw_kick_pin_t;

    typedef struct packed {
        logic reset_n;
        logic reset;
        logic fault_n;
    } srw_out_t;
endpackage

/* logic/srw_top.sv */
/*
 * supply supervisor with reset stretch and three-level watchdog.
 * assumes supply flag and kick inputs synchronous to i_clk.
 */
// Summary of operation
// R1: reset output is low while the supply-low flag is set.
// R2: reset stays low at least 140 ms after the supply-low flag clears.
// R3: a watchdog expiry gives a reset pulse of at least 140 ms.
// R4: any rising or falling kick transition restarts the timeout count.
// R5: a constant high or low kick level gives one reset pulse every 1.74 s, the 1.6 s timeout plus the 140 ms pulse.
// R6: the processor must toggle the kick input within every 1.6 s.
// R7: a floating or mid-level kick disables the watchdog, fault stays high.
// R8: the fault output goes low when no kick transition occurs in time.
// R9: the fault output returns high on the first kick after a timeout.
// R10: the fault output is forced high while the supply-low flag is set.
// R11: an active-high reset output is always the complement of reset low.
// R12: an unconnected kick input is the way to leave the watchdog off.
// R13: the timeout lies between 1.0 s and 2.25 s, 1.6 s typical.
// R14: counters with parameter terminal counts time stretch and timeout.
`timescale 1ns/1ps
`include "srw_regs.svh"
module srw_top
    import srw_pkg::*;
#(
    parameter logic [`SRW_CNT_W-1:0] STRETCH_CYC = `SRW_STRETCH_CYC,
    parameter logic [`SRW_CNT_W-1:0] TIMEOUT_CYC = `SRW_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // supply comparator
    input wire logic i_supply_low,
    // watchdog kick pin, seen as high and low level detectors
    input wire srw_kick_pin_t i_watchdog_kick_input,
    // outputs to the processor
    output logic o_reset_n,
    output logic o_reset,
    output logic o_watchdog_fault_output_n
);
    // ****************************************
    // kick classification
    // ****************************************
    function automatic srw_kick_t srw_classify(input srw_kick_pin_t p);
        if (p.drive_high && !p.drive_low) begin
            return SRW_KICK_HIGH;
        end else if (p.drive_low && !p.drive_high) begin
            return SRW_KICK_LOW;
        end
        return SRW_KICK_MID;
    endfunction

    // ****************************************
    // counter helpers
    // ****************************************
    // terminal count reached
    function automatic logic srw_at_end(
        input logic [`SRW_CNT_W-1:0] cnt,
        input logic [`SRW_CNT_W-1:0] last
    );
        return (cnt >= last - `SRW_CNT_ONE);
    endfunction

    // count one step
    function automatic logic [`SRW_CNT_W-1:0] srw_incr(
        input logic [`SRW_CNT_W-1:0] cnt
    );
        return cnt + `SRW_CNT_ONE;
    endfunction

    srw_kick_t kick_meta, kick_sync, kick_prev;
    srw_kick_t next_kick_meta, next_kick_sync, next_kick_prev;
    srw_state_t state, next_state;
    logic [`SRW_CNT_W-1:0] stretch_cnt, next_stretch_cnt;
    logic [`SRW_CNT_W-1:0] wd_cnt, next_wd_cnt;
    srw_out_t outs, next_outs;
    logic kick_edge;
    logic wd_enabled;
    logic expire;
    logic stretch_done;

    // ****************************************
    // synchroniser
    // ****************************************
    always_comb begin
        next_kick_meta = srw_classify(i_watchdog_kick_input); // [R7] [R12]
        next_kick_sync = kick_meta;
        next_kick_prev = kick_sync;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            kick_meta <= SRW_KICK_MID;
            kick_sync <= SRW_KICK_MID;
            kick_prev <= SRW_KICK_MID;
        end else begin
            kick_meta <= next_kick_meta;
            kick_sync <= next_kick_sync;
            kick_prev <= next_kick_prev;
        end
    end

    // ****************************************
    // watchdog decode
    // ****************************************
    always_comb begin
        wd_enabled = (kick_sync != SRW_KICK_MID); // [R7] [R12]
        kick_edge = wd_enabled && (kick_prev != SRW_KICK_MID)
            && (kick_sync != kick_prev); // [R4]
        expire = srw_at_end(wd_cnt, TIMEOUT_CYC); // [R13] [R14]
        stretch_done = srw_at_end(stretch_cnt, STRETCH_CYC); // [R2] [R3]
    end

    // ****************************************
    // reset sequencer
    // ****************************************
    always_comb begin
        next_state = state;
        unique case (state)
            SRW_ST_HOLD: begin
                if (!i_supply_low && stretch_done) begin
                    next_state = SRW_ST_RUN; // [R2]
                end
            end
            SRW_ST_RUN: begin
                if (i_supply_low) begin
                    next_state = SRW_ST_HOLD; // [R1]
                end else if (wd_enabled && !kick_edge && expire) begin
                    next_state = SRW_ST_PULSE; // [R3] [R5] [R6]
                end
            end
            SRW_ST_PULSE: begin
                if (i_supply_low) begin
                    next_state = SRW_ST_HOLD; // [R1]
                end else if (stretch_done) begin
                    next_state = SRW_ST_RUN; // [R3] [R5]
                end
            end
            default: begin
                next_state = SRW_ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= SRW_ST_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // reset stretch counter
    // ****************************************
    always_comb begin
        next_stretch_cnt = stretch_cnt;
        unique case (state)
            SRW_ST_HOLD, SRW_ST_PULSE: begin
                if (i_supply_low) begin
                    next_stretch_cnt = '0; // [R1]
                end else if (!stretch_done) begin
                    next_stretch_cnt = srw_incr(stretch_cnt); // [R2] [R3]
                end
            end
            SRW_ST_RUN: begin
                next_stretch_cnt = '0;
            end
            default: begin
                next_stretch_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stretch_cnt <= '0;
        end else begin
            stretch_cnt <= next_stretch_cnt;
        end
    end

    // ****************************************
    // watchdog timeout counter
    // ****************************************
    always_comb begin
        if (state != SRW_ST_RUN || i_supply_low) begin
            next_wd_cnt = '0;
        end else if (!wd_enabled || kick_edge) begin
            next_wd_cnt = '0; // [R4] [R7]
        end else if (expire) begin
            next_wd_cnt = '0; // [R5]
        end else begin
            next_wd_cnt = srw_incr(wd_cnt); // [R13] [R14]
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wd_cnt <= '0;
        end else begin
            wd_cnt <= next_wd_cnt;
        end
    end

    // ****************************************
    // output flops
    // ****************************************
    always_comb begin
        next_outs = outs;
        next_outs.reset_n = (next_state == SRW_ST_RUN); // [R1] [R2] [R3]
        next_outs.reset = (next_state != SRW_ST_RUN); // [R11]
        if (i_supply_low || !wd_enabled || kick_edge) begin
            next_outs.fault_n = 1'h1; // [R7] [R9] [R10]
        end else if (state == SRW_ST_RUN && expire) begin
            next_outs.fault_n = 1'h0; // [R8]
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            outs <= `SRW_OUT_RST;
        end else begin
            outs <= next_outs;
        end
    end

    assign o_reset_n = outs.reset_n;
    assign o_reset = outs.reset;
    assign o_watchdog_fault_output_n = outs.fault_n;
endmodule

/* sim/srw_top_sva.sv */
/* assertions on srw_top ports; assumes the bind at the foot. */
`timescale 1ns/1ps
module srw_top_sva
    import srw_pkg::*;
#(
    parameter logic [31:0] STRETCH_CYC = 32'h0000_0014,
    parameter logic [31:0] TIMEOUT_CYC = 32'h0000_0064
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_supply_low,
    input wire srw_kick_pin_t i_watchdog_kick_input,
    input wire logic o_reset_n,
    input wire logic o_reset,
    input wire logic o_watchdog_fault_output_n
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic [31:0] low_cnt, still_cnt;
    srw_kick_pin_t last_kick;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {low_cnt, still_cnt, last_kick} <= '0;
        end else begin
            low_cnt <= o_reset_n ? '0 : low_cnt + 1;
            still_cnt <= (last_kick != i_watchdog_kick_input) ? '0
                : still_cnt + 1;
            last_kick <= i_watchdog_kick_input;
        end
    end
    sequence s_kick_edge;
        ^i_watchdog_kick_input && ^last_kick
            && (i_watchdog_kick_input != last_kick);
    endsequence
    sequence s_fault_fall;
        $fell(o_watchdog_fault_output_n);
    endsequence
    a_supply_holds_reset: assert property (
        i_supply_low |=> !o_reset_n) else $error("reset high");
    a_reset_stretch_min: assert property (
        $rose(o_reset_n) |-> low_cnt >= STRETCH_CYC) else $error("short");
    a_fault_with_pulse: assert property (
        s_fault_fall |-> !o_reset_n [*8]) else $error("no pulse");
    a_quiet_before_fault: assert property (
        s_fault_fall |-> still_cnt >= TIMEOUT_CYC) else $error("early");
    a_kick_clears_fault: assert property (
        s_kick_edge |-> ##[1:4] o_watchdog_fault_output_n)
        else $error("fault kept");
    a_mid_disables: assert property (
        (!(^i_watchdog_kick_input)) [*3] |=> o_watchdog_fault_output_n)
        else $error("fault in mid");
    a_supply_fault_high: assert property (
        i_supply_low |=> o_watchdog_fault_output_n) else $error("fault");
    a_reset_complement: assert property (
        o_reset == !o_reset_n) else $error("not complement");
endmodule
bind srw_top srw_top_sva #(.STRETCH_CYC(STRETCH_CYC),
    .TIMEOUT_CYC(TIMEOUT_CYC)) u_sva (.i_clk, .i_rst_n, .i_supply_low,
    .i_watchdog_kick_input, .o_reset_n, .o_reset, .o_watchdog_fault_output_n);

/* sim/srw_cpu_model.sv */
/* processor kick driver; assumes mode 0 toggle, 1 hold, 2 float. */
`timescale 1ns/1ps
module srw_cpu_model
    import srw_pkg::*;
(
    input wire logic i_clk,
    input wire logic [1:0] i_mode,
    output srw_kick_pin_t o_kick = 2'h0
);
    logic lvl = 1'b0;
    int n = 0;
    always @(negedge i_clk) begin
        n = (i_mode == 2'h0 && n >= 40) ? 0 : n + 1;
        if (n == 0) lvl = !lvl;
        o_kick <= (i_mode == 2'h2) ? 2'h0 : {lvl, !lvl};
    end
endmodule

/* sim/srw_top_tb.sv */
/* bench for srw_top; assumes srw_cpu_model and the checker bind. */
`timescale 1ns/1ps
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %0d got %0d", nm, e, a); end end
module srw_top_tb;
    localparam int ST = 20;
    localparam int TO = 100;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_supply_low = 1'b1;
    logic [1:0] mode = 2'h2;
    srw_pkg::srw_kick_pin_t kick;
    logic o_reset_n, o_reset, fault_n;
    int n_fail = 0, check_count = 0, c;
    always #25 i_clk = !i_clk;
    srw_cpu_model CPU (.i_clk(i_clk), .i_mode(mode), .o_kick(kick));
    srw_top #(.STRETCH_CYC(ST), .TIMEOUT_CYC(TO)) DUT (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_supply_low(i_supply_low),
        .i_watchdog_kick_input(kick), .o_reset_n(o_reset_n),
        .o_reset(o_reset), .o_watchdog_fault_output_n(fault_n));
    task wt(input logic v);
        c = 0;
        while (o_reset_n !== v && c < 400) begin
            @(negedge i_clk);
            c++;
        end
        `CHK("wait_done", v, o_reset_n)
    endtask
    task t_power;
        repeat (3) @(negedge i_clk);
        `CHK("reset_n", 1'b0, o_reset_n)
        `CHK("reset", 1'b1, o_reset)
        `CHK("fault_n", 1'b1, fault_n)
        i_supply_low = 1'b0;
        wt(1'b1);
        `CHK("stretch", ST, c)
    endtask
    task t_kick;
        mode <= 2'h0;
        c = 0;
        repeat (400) @(negedge i_clk) c += (o_reset_n !== 1'b1);
        `CHK("kick_resets", 0, c)
    endtask
    task t_timeout;
        mode <= 2'h1;
        wt(1'b0);
        `CHK("fault_n", 1'b0, fault_n)
        wt(1'b1);
        `CHK("pulse", ST, c)
        wt(1'b0);
        `CHK("period", 1, c >= TO - 1 && c <= TO + 2)
        mode <= 2'h0;
        repeat (5) @(negedge i_clk);
        `CHK("fault_n", 1'b1, fault_n)
    endtask
    task t_mid;
        mode <= 2'h1;
        wt(1'b1);
        wt(1'b0);
        mode <= 2'h2;
        repeat (5) @(negedge i_clk);
        `CHK("fault_n", 1'b1, fault_n)
        wt(1'b1);
        c = 0;
        repeat (300) @(negedge i_clk) c += (o_reset_n !== 1'b1);
        `CHK("mid_resets", 0, c)
    endtask
    task t_brown;
        mode <= 2'h1;
        wt(1'b0);
        `CHK("fault_n", 1'b0, fault_n)
        i_supply_low = 1'b1;
        repeat (2 * ST) @(negedge i_clk);
        `CHK("reset_n", 1'b0, o_reset_n)
        `CHK("fault_n", 1'b1, fault_n)
        i_supply_low = 1'b0;
        wt(1'b1);
        `CHK("stretch", ST, c)
    endtask
    task final_report;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge i_clk);
        i_rst_n = 1'b1;
        t_power;
        t_kick;
        t_timeout;
        t_mid;
        t_brown;
        final_report;
    end
    initial begin
        #250000;
        n_fail++;
        final_report;
    end
endmodule
